/* hw/psw_pkg.sv */
package psw_pkg;
localparam int CLK_HZ = 100_000_000;
localparam int TICK_MS = 100;
localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
localparam int DEB_MS = 10;
localparam int DEB_CYC = CLK_HZ / 1000 * DEB_MS;
localparam int CLR_WIN_MS = 1000;
localparam logic [3:0] CLR_WIN_TICKS = 4'(CLR_WIN_MS / TICK_MS);
localparam int NOUT = 4;
localparam int NITEM = 30;
localparam logic [4:0] IT_LOCK = 5'h00;
localparam logic [4:0] IT_LOW = 5'h01;
localparam logic [4:0] IT_HIGH = 5'h02;
localparam logic [4:0] IT_DAMP = 5'h03;
localparam logic [4:0] IT_EXC = 5'h04;
localparam logic [4:0] IT_ON = 5'h05;
localparam logic [4:0] IT_OFF = 5'h09;
localparam logic [4:0] IT_MODE = 5'h0d;
localparam logic [4:0] IT_DON = 5'h11;
localparam logic [4:0] IT_DOFF = 5'h15;
localparam logic [4:0] IT_PEAK = 5'h19;
localparam logic [4:0] IT_TROUGH = 5'h1a;
localparam logic [4:0] IT_REFR = 5'h1b;
localparam logic [4:0] IT_RSTART = 5'h1c;
localparam logic [4:0] IT_LAST = 5'h1d;
localparam logic [15:0] RANGE_LO = 16'h0000;
localparam logic [15:0] RANGE_HI = 16'h0fa0;
localparam logic [15:0] MIN_SPAN = 16'((RANGE_HI - RANGE_LO) / 16'h0005);
localparam logic [15:0] DAMP_MIN = 16'h0003;
localparam logic [15:0] DAMP_MAX = 16'h012c;
localparam logic [15:0] DLY_MAX = 16'h03e8;
localparam logic [15:0] REFR_MAX = 16'h0064;
localparam logic [15:0] PW_DEFAULT = 16'h0005;
localparam logic [15:0] DISP_MAX = 16'h270f;
localparam logic [15:0] ON_DEF = 16'h0bb8;
localparam logic [15:0] OFF_DEF = 16'h07d0;
localparam logic [15:0] UA_ZERO = 16'h0fa0;
localparam logic [15:0] UA_SPAN = 16'h3e80;
localparam logic [15:0] FAULT_UA = 16'h0dac;
typedef enum logic [1:0] {ST_OPER = 2'b00, ST_BROWSE = 2'b01, ST_EDIT = 2'b11,
                          ST_PASS = 2'b10} psw_state_e;
function automatic logic [15:0] item_max(input logic [4:0] it);
    if (it == IT_LOCK || it == IT_EXC || (it >= IT_MODE && it < IT_DON)) return 16'h0001;
    if (it == IT_LOW) return RANGE_HI - MIN_SPAN;
    if (it == IT_DAMP) return DAMP_MAX;
    if (it >= IT_DON && it < IT_PEAK) return DLY_MAX;
    if (it == IT_REFR) return REFR_MAX;
    return RANGE_HI;
endfunction
function automatic logic [15:0] item_min(input logic [4:0] it);
    if (it == IT_HIGH) return RANGE_LO + MIN_SPAN;
    if (it == IT_DAMP) return DAMP_MIN;
    if (it == IT_LOW || (it >= IT_ON && it < IT_MODE)) return RANGE_LO;
    return 16'h0000;
endfunction
function automatic logic [15:0] item_def(input logic [4:0] it);
    if (it == IT_HIGH) return RANGE_HI;
    if (it == IT_DAMP) return DAMP_MIN;
    if (it >= IT_ON && it < IT_OFF) return ON_DEF;
    if (it >= IT_OFF && it < IT_MODE) return OFF_DEF;
    return item_min(it);
endfunction
endpackage

/* hw/psw_key_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface psw_key_if;
    logic up_press;
    logic down_press;
    logic both_press;
    modport src(output up_press, output down_press, output both_press);
    modport dst(input up_press, input down_press, input both_press);
endinterface
`default_nettype wire

/* hw/psw_keys.sv */
`timescale 1ns/1ps
`default_nettype none
module psw_keys import psw_pkg::*; #(
    parameter int DEB = DEB_CYC
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic key_up, // Raw up key, high when pressed
    input wire logic key_down, // Raw down key, high when pressed
    psw_key_if.src kif // Press pulses
);
    logic [1:0] raw;
    logic [1:0] db;
    logic [1:0] db_q;
    logic seen_both;
    logic release_all;
    logic is_both;
    assign raw = {key_down, key_up};
    for (genvar g = 0; g < 2; g++) begin : g_deb
        logic [23:0] cnt;
        always_ff @(posedge clk) begin
            if (reset) begin
                cnt <= 24'h000000;
                db[g] <= 1'b0;
            end else if (raw[g] == db[g]) begin
                cnt <= 24'h000000;
            end else if (cnt >= 24'(DEB - 1)) begin
                cnt <= 24'h000000;
                db[g] <= raw[g];
            end else begin
                cnt <= cnt + 24'h000001;
            end
        end
    end
    // Decide on release, so a slightly staggered press of both still counts as both
    assign release_all = (db_q != 2'b00) && (db == 2'b00);
    assign is_both = seen_both || (db_q == 2'b11);
    always_ff @(posedge clk) begin
        if (reset) begin
            db_q <= 2'b00;
            seen_both <= 1'b0;
        end else begin
            db_q <= db;
            if (db == 2'b11) seen_both <= 1'b1;
            else if (db == 2'b00) seen_both <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            kif.up_press <= 1'b0;
            kif.down_press <= 1'b0;
            kif.both_press <= 1'b0;
        end else begin
            kif.both_press <= release_all && is_both;
            kif.up_press <= release_all && !is_both && db_q[0];
            kif.down_press <= release_all && !is_both && db_q[1];
        end
    end
endmodule
`default_nettype wire

/* hw/psw_top.sv */
`timescale 1ns/1ps
`default_nettype none
module psw_top import psw_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int DEB_CYCLES = DEB_CYC
) (
    input wire logic clk, // System clock, 100 MHz
    input wire logic reset, // Synchronous reset, active high
    input wire logic [15:0] pressure, // Measured pressure, display units
    input wire logic key_up, // Up key, high when pressed
    input wire logic key_down, // Down key, high when pressed
    input wire logic fault_in, // Sensor defect
    input wire logic nv_ld_valid, // Restore one setting from storage
    input wire logic [4:0] nv_ld_addr, // Restored item
    input wire logic [15:0] nv_ld_data, // Restored value
    output logic nv_wr_en, // Store pulse
    output logic [4:0] nv_wr_addr, // Stored item
    output logic [15:0] nv_wr_data, // Stored value
    output logic [3:0] contact, // Contact outputs
    output logic [3:0] led, // Contact lamps
    output logic [27:0] seg, // Four digits, gfedcba each, left digit high
    output logic [15:0] out_ua, // Analog output in microamps
    output logic [15:0] peak, // Highest pressure
    output logic [15:0] trough, // Lowest pressure
    output logic menu_active // Menu or password entry shown
);
    psw_key_if kif();
    psw_state_e state;
    logic [15:0] cfg [NITEM];
    logic [4:0] item;
    logic [15:0] ebuf;
    logic [15:0] password;
    logic unlocked;
    logic pend_valid;
    logic [4:0] pend_item;
    logic [15:0] pend_val;
    logic [15:0] apply_val;
    logic [15:0] pend_cfg;
    logic apply;
    logic k_up;
    logic k_dn;
    logic k_both;
    logic lock_on;
    logic exc_en;
    logic [23:0] tcnt;
    logic tick;
    logic clr_armed;
    logic [3:0] clr_cnt;
    logic [15:0] damped;
    logic signed [16:0] diff;
    logic signed [16:0] step;
    logic [15:0] pd_c;
    logic [31:0] scaled;
    logic [15:0] disp_p;
    logic [6:0] rcnt;
    logic [15:0] shown;
    logic [15:0] sv;
    logic [15:0] emax;
    logic [15:0] emin;

    psw_keys #(.DEB(DEB_CYCLES)) u_keys (
        .clk(clk),
        .reset(reset),
        .key_up(key_up),
        .key_down(key_down),
        .kif(kif)
    );
    assign k_up = kif.up_press;
    assign k_dn = kif.down_press;
    assign k_both = kif.both_press;
    assign lock_on = cfg[IT_LOCK][0];
    assign exc_en = cfg[IT_EXC][0];
    assign menu_active = (state != ST_OPER);
    assign emax = (state == ST_PASS) ? DISP_MAX : item_max(item);
    assign emin = (state == ST_PASS) ? 16'h0000 : item_min(item);

    always_ff @(posedge clk) begin
        if (reset || tcnt >= 24'(TICK_CYCLES - 1)) tcnt <= 24'h000000;
        else tcnt <= tcnt + 24'h000001;
    end
    assign tick = (tcnt == 24'h000000) && !reset;

    // Menu walk; nothing writes the password after reset, so it sits at its default
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ST_OPER;
            item <= 5'h00;
            ebuf <= 16'h0000;
            unlocked <= 1'b0;
            password <= PW_DEFAULT;
        end else begin
            unique case (state)
                ST_OPER: begin
                    if (k_up || k_dn) begin
                        if (lock_on && !unlocked) begin
                            state <= ST_PASS;
                            ebuf <= 16'h0000;
                        end else begin
                            state <= ST_BROWSE;
                            item <= k_up ? 5'h00 : IT_LAST;
                        end
                    end
                end
                ST_PASS: begin
                    if (k_up && ebuf < emax) ebuf <= ebuf + 16'h0001;
                    else if (k_dn && ebuf > emin) ebuf <= ebuf - 16'h0001;
                    else if (k_both) begin
                        if (ebuf == password) begin
                            unlocked <= 1'b1;
                            state <= ST_BROWSE;
                            item <= 5'h00;
                        end else begin
                            state <= ST_OPER;
                        end
                    end
                end
                ST_BROWSE: begin
                    if (k_up) begin
                        if (item == IT_LAST) begin
                            state <= ST_OPER;
                            unlocked <= 1'b0;
                        end else begin
                            item <= item + 5'h01;
                        end
                    end else if (k_dn) begin
                        if (item == 5'h00) begin
                            state <= ST_OPER;
                            unlocked <= 1'b0;
                        end else begin
                            item <= item - 5'h01;
                        end
                    end else if (k_both && (item < IT_PEAK || item == IT_REFR)) begin
                        state <= ST_EDIT;
                        ebuf <= cfg[item];
                    end
                end
                ST_EDIT: begin
                    if (k_up && ebuf < emax) ebuf <= ebuf + 16'h0001;
                    else if (k_dn && ebuf > emin) ebuf <= ebuf - 16'h0001;
                    else if (k_both) state <= ST_BROWSE;
                end
            endcase
        end
    end

    // A confirmed value waits here until the item is left
    assign apply = pend_valid && (state == ST_BROWSE) && (k_up || k_dn);
    always_ff @(posedge clk) begin
        if (reset) begin
            pend_valid <= 1'b0;
            pend_item <= 5'h00;
            pend_val <= 16'h0000;
        end else if (state == ST_EDIT && k_both) begin
            pend_valid <= 1'b1;
            pend_item <= item;
            pend_val <= ebuf;
        end else if (apply) begin
            pend_valid <= 1'b0;
        end
    end
    assign pend_cfg = cfg[pend_item];

    always_comb begin
        apply_val = pend_val;
        if (pend_item == IT_LOW && pend_val > cfg[IT_HIGH] - MIN_SPAN)
            apply_val = cfg[IT_HIGH] - MIN_SPAN;
        else if (pend_item == IT_HIGH && pend_val < cfg[IT_LOW] + MIN_SPAN)
            apply_val = cfg[IT_LOW] + MIN_SPAN;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < NITEM; i++) cfg[i] <= item_def(5'(i));
        end else if (apply) begin
            cfg[pend_item] <= apply_val;
        end else if (nv_ld_valid && nv_ld_addr <= IT_LAST) begin
            cfg[nv_ld_addr] <= nv_ld_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            nv_wr_en <= 1'b0;
            nv_wr_addr <= 5'h00;
            nv_wr_data <= 16'h0000;
        end else begin
            nv_wr_en <= apply;
            if (apply) begin
                nv_wr_addr <= pend_item;
                nv_wr_data <= apply_val;
            end
        end
    end

    for (genvar g = 0; g < NOUT; g++) begin : g_out
        logic [15:0] on_t;
        logic [15:0] off_t;
        logic [15:0] hi;
        logic [15:0] lo;
        logic [9:0] dly;
        logic [9:0] dcnt;
        logic inv;
        logic band;
        logic win;
        logic raw;
        assign on_t = cfg[IT_ON + 5'(g)];
        assign off_t = cfg[IT_OFF + 5'(g)];
        assign inv = on_t < off_t;
        assign hi = inv ? off_t : on_t;
        assign lo = inv ? on_t : off_t;
        assign win = (pressure >= lo) && (pressure <= hi);
        always_ff @(posedge clk) begin
            if (reset) band <= 1'b0;
            else if (pressure >= hi) band <= 1'b1;
            else if (pressure <= lo) band <= 1'b0;
        end
        assign raw = cfg[IT_MODE + 5'(g)][0] ? (win ^ inv) : (band ^ inv);
        assign dly = raw ? cfg[IT_DON + 5'(g)][9:0] : cfg[IT_DOFF + 5'(g)][9:0];
        always_ff @(posedge clk) begin
            if (reset) begin
                contact[g] <= 1'b0;
                dcnt <= 10'h000;
            end else if (raw == contact[g]) begin
                dcnt <= 10'h000;
            end else if (dcnt >= dly) begin
                contact[g] <= raw;
                dcnt <= 10'h000;
            end else if (tick) begin
                dcnt <= dcnt + 10'h001;
            end
        end
    end
    assign led = contact;

    always_ff @(posedge clk) begin
        if (reset) begin
            peak <= RANGE_LO;
            trough <= RANGE_HI;
            clr_armed <= 1'b0;
            clr_cnt <= 4'h0;
        end else if (state == ST_BROWSE && k_both && (item == IT_PEAK || item == IT_TROUGH)) begin
            clr_armed <= !clr_armed;
            clr_cnt <= 4'h0;
            if (clr_armed) begin
                peak <= pressure;
                trough <= pressure;
            end
        end else begin
            if (pressure > peak) peak <= pressure;
            if (pressure < trough) trough <= pressure;
            if (clr_armed && tick) begin
                if (clr_cnt >= CLR_WIN_TICKS - 4'h1) clr_armed <= 1'b0;
                else clr_cnt <= clr_cnt + 4'h1;
            end
        end
    end

    // First-order lag stepped at the tick; a minimum step of one keeps it from stalling
    assign diff = $signed({1'b0, pressure}) - $signed({1'b0, damped});
    always_comb begin
        step = diff / $signed({1'b0, cfg[IT_DAMP]});
        if (step == 17'sd0 && diff != 17'sd0) step = (diff < 17'sd0) ? -17'sd1 : 17'sd1;
    end
    always_ff @(posedge clk) begin
        if (reset) damped <= RANGE_LO;
        else if (tick) damped <= 16'($signed({1'b0, damped}) + step);
    end

    assign pd_c = (damped < cfg[IT_LOW]) ? cfg[IT_LOW] :
                  (damped > cfg[IT_HIGH]) ? cfg[IT_HIGH] : damped;
    assign scaled = ({16'h0000, pd_c - cfg[IT_LOW]} * {16'h0000, UA_SPAN}) /
                    {16'h0000, cfg[IT_HIGH] - cfg[IT_LOW]};
    always_ff @(posedge clk) begin
        if (reset) out_ua <= UA_ZERO;
        else if (exc_en && fault_in) out_ua <= FAULT_UA;
        else out_ua <= UA_ZERO + scaled[15:0];
    end

    // Display takes raw pressure; scale points never touch it
    always_ff @(posedge clk) begin
        if (reset) begin
            disp_p <= 16'h0000;
            rcnt <= 7'h00;
        end else if (cfg[IT_REFR] == 16'h0000) begin
            disp_p <= pressure;
        end else if (tick) begin
            if ({9'h000, rcnt} >= cfg[IT_REFR] - 16'h0001) begin
                disp_p <= pressure;
                rcnt <= 7'h00;
            end else begin
                rcnt <= rcnt + 7'h01;
            end
        end
    end

    function automatic logic [6:0] seg7(input logic [3:0] d);
        unique case (d)
            4'h0: return 7'h3f;
            4'h1: return 7'h06;
            4'h2: return 7'h5b;
            4'h3: return 7'h4f;
            4'h4: return 7'h66;
            4'h5: return 7'h6d;
            4'h6: return 7'h7d;
            4'h7: return 7'h07;
            4'h8: return 7'h7f;
            4'h9: return 7'h6f;
            default: return 7'h40;
        endcase
    endfunction

    always_comb begin
        shown = disp_p;
        if (state == ST_EDIT || state == ST_PASS) shown = ebuf;
        else if (state == ST_BROWSE) begin
            unique case (item)
                IT_PEAK: shown = peak;
                IT_TROUGH: shown = trough;
                IT_RSTART: shown = RANGE_LO;
                IT_LAST: shown = RANGE_HI;
                default: shown = {11'h000, item} + 16'h0001;
            endcase
        end
    end
    assign sv = (shown > DISP_MAX) ? DISP_MAX : shown;
    always_ff @(posedge clk) begin
        if (reset) seg <= 28'h0000000;
        else seg <= {seg7(4'(sv / 16'h03e8)), seg7(4'((sv / 16'h0064) % 16'h000a)),
                     seg7(4'((sv / 16'h000a) % 16'h000a)), seg7(4'(sv % 16'h000a))};
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_UP_ENTERS_FIRST: assert property (
        state == ST_OPER && k_up && !lock_on |=> state == ST_BROWSE && item == 5'h00)
        else $error("up from operation did not reach first item");
    AST_DOWN_ENTERS_LAST: assert property (
        state == ST_OPER && k_dn && !lock_on |=> state == ST_BROWSE && item == IT_LAST)
        else $error("down from operation did not reach last item");
    AST_RING_WRAP: assert property (
        state == ST_BROWSE && item == IT_LAST && k_up |=> state == ST_OPER)
        else $error("ring did not wrap to operation");
    AST_CONFIRM_HOLDS: assert property (
        state == ST_EDIT && k_both |=> state == ST_BROWSE && pend_valid && pend_val == $past(ebuf))
        else $error("confirm did not capture edited value");
    AST_NO_EARLY_APPLY: assert property (
        pend_valid && !apply && !nv_ld_valid |=> pend_cfg == $past(pend_cfg))
        else $error("setting changed before item was left");
    AST_LOCK_ASKS_PASS: assert property (
        state == ST_OPER && lock_on && !unlocked && (k_up || k_dn) |=> state == ST_PASS)
        else $error("locked menu was entered without password");
    AST_SPAN_KEPT: assert property (
        apply && (pend_item == IT_LOW || pend_item == IT_HIGH)
        |=> cfg[IT_HIGH] - cfg[IT_LOW] >= MIN_SPAN)
        else $error("scale span below minimum");
    AST_UA_RANGE: assert property (
        !(exc_en && fault_in) |=> out_ua >= UA_ZERO && out_ua <= UA_ZERO + UA_SPAN)
        else $error("analog output outside 4 to 20 mA");
    AST_FAULT_GATED: assert property (
        exc_en && fault_in |=> out_ua == FAULT_UA)
        else $error("fault level not driven while enabled");
    AST_CONTACT_CAUSE: assert property (
        $rose(contact[0]) |-> $past(g_out[0].raw))
        else $error("contact rose without switch-on condition");
    COV_EDIT_APPLY: cover property (state == ST_EDIT && k_both ##[1:50] apply);
    COV_UNLOCK: cover property (state == ST_PASS && k_both ##1 state == ST_BROWSE);
    COV_PEAK_CLEAR: cover property (clr_armed && k_both && item == IT_PEAK);
    COV_FAULT: cover property (out_ua == FAULT_UA);
endmodule
`default_nettype wire

/* test/psw_operator.sv */
`timescale 1ns/1ps
`default_nettype none
module psw_operator #(
    parameter int DEB = 3
) (
    input wire logic clk, // System clock
    output logic key_up, // Up key level
    output logic key_down // Down key level
);
    initial begin
        key_up = 1'b0;
        key_down = 1'b0;
    end
    // Held well past the debounce span: a steady hand, not a bounce
    task automatic press(input logic up, input logic down);
        @(negedge clk);
        key_up = up;
        key_down = down;
        repeat (DEB + 4) @(negedge clk);
        key_up = 1'b0;
        key_down = 1'b0;
        repeat (DEB + 8) @(negedge clk);
    endtask
endmodule
`default_nettype wire

/* test/psw_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module psw_top_bench import psw_pkg::*;;
    logic clk, reset, key_up, key_down, fault_in, nv_ld_valid, nv_wr_en, menu_active;
    logic [4:0] nv_ld_addr, nv_wr_addr;
    logic [15:0] pressure, nv_ld_data, nv_wr_data, out_ua, peak, trough;
    logic [3:0] contact, led;
    logic [27:0] seg;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int nv_writes = 0;
    psw_operator #(.DEB(3)) op (.clk(clk), .key_up(key_up), .key_down(key_down));
    psw_top #(.TICK_CYCLES(20), .DEB_CYCLES(3)) dut (.clk(clk), .reset(reset),
        .pressure(pressure), .key_up(key_up), .key_down(key_down), .fault_in(fault_in),
        .nv_ld_valid(nv_ld_valid), .nv_ld_addr(nv_ld_addr), .nv_ld_data(nv_ld_data),
        .nv_wr_en(nv_wr_en), .nv_wr_addr(nv_wr_addr), .nv_wr_data(nv_wr_data),
        .contact(contact), .led(led), .seg(seg), .out_ua(out_ua), .peak(peak),
        .trough(trough), .menu_active(menu_active));
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_seg(input string name, input logic [27:0] exp, input logic [27:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One-cycle restore strobe, as the storage side would give it at power-up
    task automatic nv_load(input logic [4:0] addr, input logic [15:0] data);
        @(negedge clk);
        nv_ld_addr = addr;
        nv_ld_data = data;
        nv_ld_valid = 1'b1;
        @(negedge clk);
        nv_ld_valid = 1'b0;
    endtask
    task automatic complete_run();
        if (fail_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Store pulses stand one cycle, so count them as they pass
    always @(negedge clk) begin
        if (nv_wr_en === 1'b1) nv_writes++;
    end
    // The whole sequence needs about 4000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        reset = 1'b1;
        pressure = 16'h0000;
        fault_in = 1'b0;
        nv_ld_valid = 1'b0;
        nv_ld_addr = 5'h00;
        nv_ld_data = 16'h0000;
        repeat (6) @(negedge clk);
        check("out_ua", 16'h0fa0, out_ua);
        check("contact", 16'h0000, {12'h000, contact});
        check("trough", 16'h0fa0, trough);
        reset = 1'b0;
        pressure = 16'h0fa0;
        // Damping closes a third of the gap each tick, so allow ample ticks to settle
        repeat (2000) @(negedge clk);
        check("out_ua", 16'h4e20, out_ua);
        check("contact", 16'h000f, {12'h000, contact});
        check("led", 16'h000f, {12'h000, led});
        check("peak", 16'h0fa0, peak);
        pressure = 16'h09c4;
        repeat (3) @(negedge clk);
        check("contact", 16'h000f, {12'h000, contact});
        pressure = 16'h07d0;
        repeat (3) @(negedge clk);
        check("contact", 16'h0000, {12'h000, contact});
        pressure = 16'h09c4;
        op.press(1'b1, 1'b0);
        check("menu_active", 16'h0001, {15'h0000, menu_active});
        op.press(1'b0, 1'b1);
        check("menu_active", 16'h0000, {15'h0000, menu_active});
        check_seg("seg", {7'h5b, 7'h6d, 7'h3f, 7'h3f}, seg);
        op.press(1'b0, 1'b1);
        check("menu_active", 16'h0001, {15'h0000, menu_active});
        op.press(1'b1, 1'b0);
        check("menu_active", 16'h0000, {15'h0000, menu_active});
        repeat (14) op.press(1'b1, 1'b0);
        op.press(1'b1, 1'b1);
        op.press(1'b1, 1'b0);
        op.press(1'b1, 1'b1);
        check("contact", 16'h0000, {12'h000, contact});
        op.press(1'b1, 1'b0);
        check("contact", 16'h0001, {12'h000, contact});
        check("nv_wr_addr", {11'h000, IT_MODE}, {11'h000, nv_wr_addr});
        check("nv_wr_data", 16'h0001, nv_wr_data);
        check_seg("seg", {7'h3f, 7'h3f, 7'h06, 7'h6d}, seg);
        // Fault level only counts once the exceed setting is restored on
        fault_in = 1'b1;
        repeat (1000) @(negedge clk);
        check("out_ua", 16'h36b0, out_ua);
        nv_load(IT_EXC, 16'h0001);
        repeat (2) @(negedge clk);
        check("out_ua", 16'h0dac, out_ua);
        fault_in = 1'b0;
        repeat (2) @(negedge clk);
        check("out_ua", 16'h36b0, out_ua);
        repeat (11) op.press(1'b1, 1'b0);
        check_seg("seg", {7'h66, 7'h3f, 7'h3f, 7'h3f}, seg);
        check("trough", 16'h07d0, trough);
        op.press(1'b1, 1'b1);
        op.press(1'b1, 1'b1);
        check("peak", 16'h09c4, peak);
        check("trough", 16'h09c4, trough);
        repeat (5) op.press(1'b1, 1'b0);
        check("menu_active", 16'h0000, {15'h0000, menu_active});
        nv_load(IT_LOCK, 16'h0001);
        op.press(1'b0, 1'b1);
        op.press(1'b1, 1'b1);
        check("menu_active", 16'h0000, {15'h0000, menu_active});
        op.press(1'b0, 1'b1);
        repeat (5) op.press(1'b1, 1'b0);
        check_seg("seg", {7'h3f, 7'h3f, 7'h3f, 7'h6d}, seg);
        op.press(1'b1, 1'b1);
        check("menu_active", 16'h0001, {15'h0000, menu_active});
        check("nv_writes", 16'h0001, 16'(nv_writes));
        complete_run();
    end
endmodule
`default_nettype wire
